// *** hw/fpia_pkg.sv ***
package fpia_pkg;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // CTRL fields
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_TEMP_UNPROT_BIT = 4;
  localparam int CTRL_BOOT_WP_BIT = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // STATUS fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_SECURE_BIT = 2;
  localparam int STAT_LOCKED_BIT = 3;
  localparam int STAT_PROTECTED_BIT = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Device command addresses and data (word mode)
  localparam logic [20:0] CMD_ADDR_A = 21'h00_0555;
  localparam logic [20:0] CMD_ADDR_B = 21'h00_02AA;
  localparam logic [15:0] CMD_UNLOCK_A = 16'h00AA;
  localparam logic [15:0] CMD_UNLOCK_B = 16'h0055;
  localparam logic [15:0] CMD_ENTER_SECURE = 16'h0088;
  localparam logic [15:0] CMD_EXIT_PREFIX = 16'h0090;
  localparam logic [15:0] CMD_EXIT_FINAL = 16'h0000;
  // Id access low address: high-voltage pin at logic 1, mode qualifier low, query bit selects
  localparam logic [11:0] ID_LOW_ADDR = 12'h200;
  localparam logic [11:0] PROT_LOW_ADDR = 12'h202;
  localparam int SECTOR_LSB = 12;
  localparam int LOCK_BIT = 7;
  // Timing
  localparam int CLK_NS = 4;
  localparam int GLITCH_NS = 5;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_NS = 40;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_NS = 100;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_PULSE_NS = 500;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RESET_RECOVER_NS = 200;
  localparam int RESET_RECOVER_CYC = (RESET_RECOVER_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ID_READ, OP_PROT_QUERY,
    OP_ENTER_SECURE, OP_EXIT_SECURE, OP_RESET_PULSE, OP_SPARE
  } fpia_op_e;

  typedef struct packed {
    logic ceN;
    logic oeN;
    logic weN;
    logic resetN;
    logic resetHv;
    logic idHv;
    logic wpN;
    logic [20:0] addr;
    logic [15:0] dqOut;
    logic dqOe;
  } fpia_pins_s;
endpackage

// *** hw/fpia_host.sv ***
`timescale 1ns/1ps
// How it works
// - Id read: high voltage on id pin, selects and qualifier bits low, code bit picks.
// - Protect query: high voltage, write strobe and query bit high, sector on top lines.
// - Lock uses enter sequence with reset pin high or high voltage.
// - Host offers the exit sequence to leave secure mode after locking.
// - Writes only with select and write low, output enable high.
module fpia_host import fpia_pkg::*; #(
  parameter int StrobeCyc = STROBE_CYC,
  parameter int AccessCyc = ACCESS_CYC,
  parameter int ResetPulseCyc = RESET_PULSE_CYC,
  parameter int ResetRecoverCyc = RESET_RECOVER_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output fpia_pins_s flashPins,
  input wire logic [15:0] flashDqIn
);
  // Strobe must outlast the glitch filter or the device drops the write
  if (StrobeCyc <= GLITCH_CYC || StrobeCyc > 255) begin : g_strobe_check
    $error("fpia_host: strobe width out of range");
  end
  // Read data must stand half a cycle on the pins before it is sampled
  if (AccessCyc < 2 || AccessCyc > 255) begin : g_access_check
    $error("fpia_host: access time out of range");
  end
  if (ResetPulseCyc < 1 || ResetPulseCyc > 255 || ResetRecoverCyc < 1 ||
      ResetRecoverCyc > 255) begin : g_reset_check
    $error("fpia_host: reset timing out of range");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_READ, ST_RST_LOW, ST_RST_WAIT
  } fpia_state_e;

  fpia_state_e state;
  fpia_op_e op;
  logic [1:0] step;
  logic [7:0] timer;
  logic tempUnprotect;
  logic bootWriteProtect;
  logic [20:0] userAddr;
  logic [15:0] userData;
  logic [15:0] readData;
  logic busy;
  logic done;
  logic secureMode;
  logic lockIndicator;
  logic sectorProtected;

  // Register bus decode
  wire writeFire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready;
  wire readFire = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  wire wrCtrl = writeFire && s_axi_awaddr == REG_CTRL && s_axi_wstrb[0];
  wire wrAddr = writeFire && s_axi_awaddr == REG_ADDR;
  wire wrData = writeFire && s_axi_awaddr == REG_WDATA;
  wire wrMapped = s_axi_awaddr == REG_CTRL || s_axi_awaddr == REG_ADDR ||
                  s_axi_awaddr == REG_WDATA || s_axi_awaddr == REG_STATUS ||
                  s_axi_awaddr == REG_RDATA;
  wire startReq = wrCtrl && s_axi_wdata[CTRL_START_BIT] && state == ST_IDLE;
  wire fpia_op_e reqOp = fpia_op_e'(s_axi_wdata[CTRL_OP_LSB +: 3]);
  wire [31:0] ctrlRead = {26'h0, bootWriteProtect, tempUnprotect, op, 1'b0};
  wire [31:0] statusRead = {27'h0, sectorProtected, lockIndicator, secureMode, done, busy};
  wire rdMapped = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_ADDR ||
                  s_axi_araddr == REG_WDATA || s_axi_araddr == REG_STATUS ||
                  s_axi_araddr == REG_RDATA;
  wire [31:0] readMux = s_axi_araddr == REG_CTRL ? ctrlRead :
                        s_axi_araddr == REG_ADDR ? {11'h0, userAddr} :
                        s_axi_araddr == REG_WDATA ? {16'h0, userData} :
                        s_axi_araddr == REG_STATUS ? statusRead :
                        s_axi_araddr == REG_RDATA ? {16'h0, readData} : 32'h0000_0000;

  // Sequence step tables
  wire [1:0] lastStep = op == OP_ENTER_SECURE ? 2'd2 :
                        op == OP_EXIT_SECURE ? 2'd3 : 2'd0;
  wire isReadOp = op == OP_READ || op == OP_ID_READ || op == OP_PROT_QUERY;
  wire [20:0] unlockAddr = step == 2'd1 ? CMD_ADDR_B : CMD_ADDR_A;
  wire [15:0] unlockData = step == 2'd0 ? CMD_UNLOCK_A :
                           step == 2'd1 ? CMD_UNLOCK_B :
                           op == OP_ENTER_SECURE ? CMD_ENTER_SECURE : CMD_EXIT_PREFIX;
  wire [20:0] idAddr = {9'h000, ID_LOW_ADDR | {11'h000, userAddr[0]}};
  // Address bit 0 set reaches the lock indicator word instead of sector status
  wire [20:0] protAddr = {userAddr[20:SECTOR_LSB], PROT_LOW_ADDR | {11'h000, userAddr[0]}};
  wire [20:0] stepAddr = op == OP_ID_READ ? idAddr :
                         op == OP_PROT_QUERY ? protAddr :
                         op == OP_EXIT_SECURE && step == 2'd3 ? 21'h00_0000 :
                         op == OP_ENTER_SECURE || op == OP_EXIT_SECURE ? unlockAddr :
                         userAddr;
  wire [15:0] stepData = op == OP_EXIT_SECURE && step == 2'd3 ? CMD_EXIT_FINAL :
                         op == OP_ENTER_SECURE || op == OP_EXIT_SECURE ? unlockData :
                         userData;
  wire idSpace = op == OP_ID_READ || op == OP_PROT_QUERY;
  wire timerDone = timer == 8'h00;

  // AXI4-Lite slave
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= writeFire;
      s_axi_wready <= writeFire;
      if (writeFire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= readFire;
      if (readFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readMux;
        s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      tempUnprotect <= CTRL_RESET[CTRL_TEMP_UNPROT_BIT];
      bootWriteProtect <= CTRL_RESET[CTRL_BOOT_WP_BIT];
      userAddr <= 21'h00_0000;
      userData <= 16'h0000;
    end else begin
      if (wrCtrl) begin
        tempUnprotect <= s_axi_wdata[CTRL_TEMP_UNPROT_BIT];
        bootWriteProtect <= s_axi_wdata[CTRL_BOOT_WP_BIT];
      end
      if (wrAddr) begin
        userAddr <= s_axi_wdata[20:0];
      end
      if (wrData) begin
        userData <= s_axi_wdata[15:0];
      end
    end
  end

  // Bus cycle sequencer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      op <= OP_READ;
      step <= 2'd0;
      timer <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      readData <= 16'h0000;
      secureMode <= 1'b0;
      lockIndicator <= 1'b0;
      sectorProtected <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (startReq) begin
            op <= reqOp;
            step <= 2'd0;
            busy <= 1'b1;
            done <= 1'b0;
            state <= reqOp == OP_RESET_PULSE ? ST_RST_LOW : ST_SETUP;
            timer <= reqOp == OP_RESET_PULSE ? 8'(ResetPulseCyc - 1) : 8'h00;
          end
        end
        ST_SETUP: begin
          state <= isReadOp ? ST_READ : ST_STROBE;
          timer <= isReadOp ? 8'(AccessCyc - 1) : 8'(StrobeCyc - 1);
        end
        ST_STROBE: begin
          if (timerDone) begin
            state <= ST_HOLD;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        ST_READ: begin
          if (timerDone) begin
            readData <= flashDqIn;
            if (idSpace) begin
              lockIndicator <= flashDqIn[LOCK_BIT];
              sectorProtected <= flashDqIn[0];
            end
            state <= ST_HOLD;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        ST_HOLD: begin
          if (step == lastStep) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
            if (op == OP_ENTER_SECURE) begin
              secureMode <= 1'b1;
            end else if (op == OP_EXIT_SECURE) begin
              secureMode <= 1'b0;
            end
          end else begin
            step <= step + 2'd1;
            state <= ST_SETUP;
          end
        end
        ST_RST_LOW: begin
          if (timerDone) begin
            state <= ST_RST_WAIT;
            timer <= 8'(ResetRecoverCyc - 1);
            secureMode <= 1'b0;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        ST_RST_WAIT: begin
          if (timerDone) begin
            state <= ST_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end else begin
            timer <= timer - 8'h01;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // Pin drive; strobes idle high from reset so nothing forms a command
  wire inCycle = state == ST_SETUP || state == ST_STROBE || state == ST_READ;
  wire fpia_pins_s next_pins = '{
    ceN: !(inCycle || state == ST_HOLD && !isReadOp),
    oeN: !(isReadOp && (state == ST_READ)),
    weN: !(state == ST_STROBE),
    resetN: !(state == ST_RST_LOW),
    resetHv: tempUnprotect && state != ST_RST_LOW,
    idHv: idSpace && (inCycle || state == ST_HOLD),
    wpN: !bootWriteProtect,
    addr: stepAddr,
    dqOut: stepData,
    dqOe: !isReadOp && (inCycle || state == ST_HOLD)
  };

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flashPins <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, resetN: 1'b1, resetHv: 1'b0,
                     idHv: 1'b0, wpN: 1'b1, addr: 21'h00_0000, dqOut: 16'h0000, dqOe: 1'b0};
    end else begin
      flashPins <= next_pins;
    end
  end
endmodule

// *** verif/fpia_host_assertions.sv ***
`timescale 1ns/1ps
module fpia_host_assertions import fpia_pkg::*; #(
  parameter int StrobeCyc = STROBE_CYC,
  parameter int ResetPulseCyc = RESET_PULSE_CYC
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire fpia_pins_s flashPins
);
  wire fpia_pins_s p = flashPins;
  int lowCnt;
  int rstCnt;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lowCnt <= 0;
      rstCnt <= 0;
    end else begin
      lowCnt <= p.weN ? 0 : lowCnt + 1;
      rstCnt <= p.resetN ? 0 : rstCnt + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
    && !s_axi_awready |=> s_axi_awready && s_axi_wready && s_axi_bvalid) else $error("no bvalid");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready
    |=> s_axi_arready && s_axi_rvalid) else $error("no rvalid");
  a_write_qualify: assert property (!p.weN |-> !p.ceN && p.oeN && p.dqOe)
    else $error("bad write qualifiers");
  a_strobe_width: assert property ($rose(p.weN) |-> lowCnt == StrobeCyc)
    else $error("strobe width");
  a_read_release: assert property (!p.oeN |-> p.weN && !p.dqOe)
    else $error("drive during read");
  a_hv_level: assert property (p.resetHv |-> p.resetN)
    else $error("high voltage with reset low");
  a_id_select: assert property (p.idHv && !p.oeN |-> !p.ceN && p.weN && !p.addr[6])
    else $error("id access selects");
  a_pulse_width: assert property ($rose(p.resetN) |-> rstCnt == ResetPulseCyc)
    else $error("reset pulse width");
  a_pulse_quiet: assert property (!p.resetN |-> p.weN && p.oeN)
    else $error("strobes in reset pulse");
  a_power_quiet: assert property (disable iff (1'b0) !reset_n |-> p.weN && p.ceN && p.oeN)
    else $error("strobes in reset");
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  cover property (p.idHv && !p.oeN);
  cover property (p.resetHv && !p.weN);
  cover property (!p.wpN && !p.weN);
endmodule
bind fpia_host fpia_host_assertions #(
  .StrobeCyc(StrobeCyc),
  .ResetPulseCyc(ResetPulseCyc)
) chk (.*);

// *** verif/fpia_flash_model.sv ***
`timescale 1ns/1ps
module fpia_flash_model import fpia_pkg::*; #(
  parameter logic [15:0] MfrCode = 16'h005A, // Arbitrary value
  parameter logic [15:0] DevCode = 16'h1234, // Arbitrary value
  parameter logic [15:0] Serial = 16'h5E71,
  parameter logic [8:0] ProtSector = 9'h040,
  parameter bit TopBoot = 1'b0,
  parameter bit FactoryLocked = 1'b1
) (
  input wire logic core_clk,
  input wire fpia_pins_s p,
  output logic [15:0] dq
);
  logic [15:0] mem [logic [21:0]];
  logic [2:0] cyc = 3'h0;
  logic sec = 1'b0;
  // Writes before the first strobe fall are never accepted
  realtime tFall = 1.0e9;
  wire [20:0] a = p.addr;
  wire [21:0] key = {sec, a};
  wire prot = a[20:12] == ProtSector;
  wire boot = TopBoot ? &a[20:13] : ~|a[20:13];
  wire blocked = sec ? FactoryLocked
    : (boot && !p.wpN) || (prot && !p.resetHv);
  initial mem[{1'b1, TopBoot ? 21'h1F8000 : 21'h000000}] = Serial;
  initial dq = 16'h0000;
  // Off the bus the lines toggle, so stale data never looks valid
  always @(negedge core_clk) begin
    if (!p.ceN && !p.oeN && p.resetN) begin
      if (p.idHv)
        dq <= a[1] ? (a[0] ? {8'h00, FactoryLocked, 7'h19} : {15'h0, prot})
          : (a[0] ? DevCode : MfrCode);
      else
        dq <= mem.exists(key) ? mem[key] : 16'hFFFF;
    end else
      dq <= ~dq;
  end
  always @(negedge p.weN) tFall = $realtime;
  always @(negedge p.resetN) begin
    cyc = 3'h0;
    sec = 1'b0;
  end
  always @(posedge p.weN) begin
    if (!p.ceN && p.oeN && p.resetN && $realtime - tFall >= GLITCH_NS) begin
      if (cyc == 3'h3) begin
        if (!blocked) mem[key] = p.dqOut;
        cyc = 3'h0;
      end else if (cyc == 3'h4) begin
        if (p.dqOut == CMD_EXIT_FINAL) sec = 1'b0;
        cyc = 3'h0;
      end else if (cyc == 3'h0 && a == CMD_ADDR_A && p.dqOut == CMD_UNLOCK_A) cyc = 3'h1;
      else if (cyc == 3'h1 && a == CMD_ADDR_B && p.dqOut == CMD_UNLOCK_B) cyc = 3'h2;
      else if (cyc == 3'h2 && a == CMD_ADDR_A) begin
        cyc = p.dqOut == 16'h00A0 ? 3'h3 : p.dqOut == CMD_EXIT_PREFIX ? 3'h4 : 3'h0;
        if (p.dqOut == CMD_ENTER_SECURE) sec = 1'b1;
      end else cyc = 3'h0;
    end
  end
endmodule

// *** verif/fpia_host_test.sv ***
`timescale 1ns/1ps
module fpia_host_test import fpia_pkg::*;;
  localparam logic [15:0] Mfr = 16'h005A; // Arbitrary value
  localparam logic [15:0] Dev = 16'h1234; // Arbitrary value
  localparam logic [15:0] Ser = 16'h5E71;
  logic core_clk = 1'b0;
  logic reset_n = 1'b1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, ctl = 2'h0;
  fpia_pins_s pins;
  logic [15:0] dq;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  always #2 core_clk = ~core_clk;
  fpia_host #(.StrobeCyc(3), .AccessCyc(2), .ResetPulseCyc(2), .ResetRecoverCyc(2)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .flashPins(pins), .flashDqIn(dq));
  fpia_flash_model #(.MfrCode(Mfr), .DevCode(Dev), .Serial(Ser)) dev (
    .core_clk(core_clk), .p(pins), .dq(dq));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkResp(input string what, input logic [1:0] exp, input logic [1:0] got);
    chk(what, {30'h0, exp}, {30'h0, got});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awTaken;
    logic wTaken;
    awTaken = 1'b0;
    wTaken = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1) begin
        awTaken = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wTaken = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(awTaken && wTaken));
    while (bvalid !== 1'b1) @(posedge core_clk);
    r = bresp;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge core_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic op(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d);
    logic [1:0] r;
    logic [31:0] s;
    wr(REG_ADDR, {11'h0, a}, r);
    wr(REG_WDATA, {16'h0, d}, r);
    wr(REG_CTRL, {26'h0, ctl, o, 1'b1}, r);
    do rd(REG_STATUS, s, r); while (s[STAT_DONE_BIT] !== 1'b1);
  endtask
  task automatic look(input logic [2:0] o, input logic [20:0] a, input logic [31:0] exp);
    logic [1:0] r;
    logic [31:0] s;
    op(o, a, 16'h0);
    rd(REG_RDATA, s, r);
    chk("flash data", exp, s);
  endtask
  // Program sequence, then read back
  task automatic prog(input logic [20:0] a, input logic [15:0] d, input logic [31:0] exp);
    op(OP_WRITE, CMD_ADDR_A, CMD_UNLOCK_A);
    op(OP_WRITE, CMD_ADDR_B, CMD_UNLOCK_B);
    op(OP_WRITE, CMD_ADDR_A, 16'h00A0);
    op(OP_WRITE, a, d);
    look(OP_READ, a, exp);
  endtask
  task automatic stat(input int b, input logic v);
    logic [1:0] r;
    logic [31:0] s;
    rd(REG_STATUS, s, r);
    chk("status bit", {31'h0, v}, {31'h0, s[b]});
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      print_verdict;
    end
  end
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    // Falling edge at time zero resets the design before the first clock
    reset_n <= 1'b0;
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(REG_STATUS, s, r);
    chk("status at reset", 32'h0, s);
    rd(8'h20, s, r);
    chkResp("unmapped read", RESP_SLVERR, r);
    wr(8'h24, 32'h0, r);
    chkResp("unmapped write", RESP_SLVERR, r);
    look(OP_ID_READ, 21'h0, Mfr);
    look(OP_ID_READ, 21'h1, Dev);
    look(OP_PROT_QUERY, 21'h040000, 32'h1);
    stat(STAT_PROTECTED_BIT, 1'b1);
    look(OP_PROT_QUERY, 21'h041000, 32'h0);
    look(OP_PROT_QUERY, 21'h000001, 32'h0099);
    stat(STAT_LOCKED_BIT, 1'b1);
    prog(21'h041000, 16'h1234, 32'h1234);
    prog(21'h040000, 16'h0F0F, 32'hFFFF);
    ctl = 2'b01;
    prog(21'h040000, 16'h0F0F, 32'h0F0F);
    ctl = 2'b00;
    prog(21'h040001, 16'h0F0F, 32'hFFFF);
    ctl = 2'b10;
    prog(21'h000010, 16'hA5A5, 32'hFFFF);
    ctl = 2'b00;
    prog(21'h000010, 16'hA5A5, 32'hA5A5);
    op(OP_ENTER_SECURE, 21'h0, 16'h0);
    stat(STAT_SECURE_BIT, 1'b1);
    look(OP_READ, 21'h0, Ser);
    prog(21'h0, 16'h0000, Ser);
    op(OP_EXIT_SECURE, 21'h0, 16'h0);
    stat(STAT_SECURE_BIT, 1'b0);
    look(OP_READ, 21'h000010, 32'hA5A5);
    op(OP_ENTER_SECURE, 21'h0, 16'h0);
    op(OP_RESET_PULSE, 21'h0, 16'h0);
    stat(STAT_SECURE_BIT, 1'b0);
    look(OP_READ, 21'h0, 32'hFFFF);
    print_verdict;
  end
endmodule
